// [hdl/fws_apb_regs.sv]
// Module: APB slave register file of the polling controller
module fws_apb_regs (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             start_o,
   output logic             mode_erase_o,
   output logic      [21:0] addr_o,
   output logic      [7:0]  data_o,
   input  wire logic [3:0]  status_i,
   input  wire logic [7:0]  last_i
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic        mode_r;
   logic [21:0] addr_r;
   logic [7:0]  data_r;
   wire         acc      = psel_i & penable_i;
   wire         hit_ctrl = paddr_i == fws_pkg::REG_CTRL;
   wire         hit_addr = paddr_i == fws_pkg::REG_ADDR;
   wire         hit_data = paddr_i == fws_pkg::REG_DATA;
   wire         hit_st   = paddr_i == fws_pkg::REG_STATUS;
   wire         hit_last = paddr_i == fws_pkg::REG_LAST;
   wire         mapped   = hit_ctrl | hit_addr | hit_data | hit_st | hit_last;
   assign pready_o     = 1'b1;
   assign pslverr_o    = acc & ~mapped;
   assign start_o      = acc & pwrite_i & hit_ctrl & pwdata_i[fws_pkg::CTRL_START];
   assign mode_erase_o = mode_r;
   assign addr_o       = addr_r;
   assign data_o       = data_r;
   assign prdata_o     = hit_ctrl ? {30'h0, mode_r, 1'b0} :
                         hit_addr ? {10'h0, addr_r} :
                         hit_data ? {24'h0, data_r} :
                         hit_st   ? {28'h0, status_i} :
                         hit_last ? {24'h0, last_i} : 32'h0000_0000;
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         mode_r <= 1'b0;
         addr_r <= 22'h0;
         data_r <= 8'h00;
      end else if (acc && pwrite_i) begin
         if (hit_ctrl) mode_r <= pwdata_i[fws_pkg::CTRL_MODE];
         if (hit_addr) addr_r <= pwdata_i[21:0];
         if (hit_data) data_r <= pwdata_i[7:0];
      end
   end
endmodule : fws_apb_regs

// [hdl/fws_pkg.sv]
// Package: constants for the flash write-status polling controller
package fws_pkg;
   // ----------------------------------------------------------------
   // Register map (APB byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_LAST   = 8'h10;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_START   = 0;
   localparam int CTRL_MODE    = 1;
   localparam int ST_BUSY      = 0;
   localparam int ST_DONE      = 1;
   localparam int ST_FAIL      = 2;
   localparam int ST_RB        = 3;
   localparam int BIT_POL      = 7;
   localparam int BIT_TOG      = 6;
   localparam int BIT_TMO      = 5;
   localparam int BIT_SECT     = 2;
   // ----------------------------------------------------------------
   // Flash read cycle timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ      = 40;
   localparam int T_ACC_NS     = 70;
   localparam int ACC_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int GAP_CYC      = 1;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   localparam logic [7:0]  RESET_CMD   = 8'hF0;
   typedef enum logic [2:0] {
      FWS_IDLE  = 3'b000,
      FWS_READ  = 3'b001,
      FWS_EVAL  = 3'b010,
      FWS_RST   = 3'b011,
      FWS_GAP   = 3'b100
   } fws_state_t;
endpackage : fws_pkg

// [hdl/fws_poller.sv]
// Module: host-side flash write-status polling controller
// How it works
// - Host polls a program at the very address being programmed.
// - Host polls an erase inside a selected, unprotected sector.
// - Polarity may settle before low bits; host rereads before trusting data.
// - Host compares the toggle bit of two consecutive reads; no change with polarity matching means done.
// - Toggling with timeout flag high: recheck, then fail and send reset.
// - After interruption, host restarts detection from its first paired read.
module fws_poller #(
   parameter int ACC = fws_pkg::ACC_CYC
) (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic      [21:0] fl_addr_o,
   output logic      [7:0]  fl_dq_o,
   output logic             fl_dq_oe_o,
   input  wire logic [7:0]  fl_dq_i,
   output logic             fl_ce_n_o,
   output logic             fl_oe_n_o,
   output logic             fl_we_n_o,
   input  wire logic        ready_busy_pin_i
);
   // ----------------------------------------------------------------
   // Registers and wires
   // ----------------------------------------------------------------
   fws_pkg::fws_state_t state_r, state_nxt;
   logic        start;
   logic        mode_erase;
   logic [21:0] addr;
   logic [7:0]  data;
   logic [7:0]  cnt_r;
   logic [7:0]  prev_r;
   logic [7:0]  last_r;
   logic        have_prev_r;
   logic        tmo_seen_r;
   logic        busy_r;
   logic        done_r;
   logic        fail_r;
   logic        rb_r;
   logic        fl_oe_n_r;
   logic        fl_we_n_r;
   logic        fl_dq_oe_r;
   wire         cnt_end  = cnt_r == 8'(ACC - 1);
   wire         toggling = (prev_r[fws_pkg::BIT_TOG] != last_r[fws_pkg::BIT_TOG]);
   wire         timeout  = last_r[fws_pkg::BIT_TMO];
   // Program polling: polarity must match datum; erase: polarity reads one
   wire         pol_ok   = mode_erase ? last_r[fws_pkg::BIT_POL]
                                      : (last_r[fws_pkg::BIT_POL] == data[fws_pkg::BIT_POL]);
   wire [3:0]   status   = {rb_r, fail_r, done_r, busy_r};
   fws_apb_regs u_regs (
      .clock_i      (clock_i),
      .srst_i       (srst_i),
      .psel_i       (psel_i),
      .penable_i    (penable_i),
      .pwrite_i     (pwrite_i),
      .paddr_i      (paddr_i),
      .pwdata_i     (pwdata_i),
      .prdata_o     (prdata_o),
      .pready_o     (pready_o),
      .pslverr_o    (pslverr_o),
      .start_o      (start),
      .mode_erase_o (mode_erase),
      .addr_o       (addr),
      .data_o       (data),
      .status_i     (status),
      .last_i       (last_r)
   );
   assign fl_addr_o  = addr;
   assign fl_ce_n_o  = ~(fl_oe_n_r == 1'b0 || fl_we_n_r == 1'b0);
   assign fl_oe_n_o  = fl_oe_n_r;
   assign fl_we_n_o  = fl_we_n_r;
   assign fl_dq_oe_o = fl_dq_oe_r;
   assign fl_dq_o    = fws_pkg::RESET_CMD;
   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         fws_pkg::FWS_IDLE: if (start) state_nxt = fws_pkg::FWS_READ;
         fws_pkg::FWS_READ: if (cnt_end) state_nxt = fws_pkg::FWS_EVAL;
         fws_pkg::FWS_EVAL: begin
            if (!have_prev_r) state_nxt = fws_pkg::FWS_GAP;
            else if (!toggling && pol_ok) state_nxt = fws_pkg::FWS_IDLE;
            else if (toggling && tmo_seen_r) state_nxt = fws_pkg::FWS_RST;
            else state_nxt = fws_pkg::FWS_GAP;
         end
         fws_pkg::FWS_RST:  if (cnt_end) state_nxt = fws_pkg::FWS_IDLE;
         fws_pkg::FWS_GAP:  state_nxt = fws_pkg::FWS_READ;
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) state_r <= fws_pkg::FWS_IDLE;
      else state_r <= state_nxt;
   end
   always_ff @(posedge clock_i) begin
      if (srst_i || state_r != state_nxt) cnt_r <= 8'h00;
      else cnt_r <= cnt_r + 8'h01;
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         fl_oe_n_r  <= 1'b1;
         fl_we_n_r  <= 1'b1;
         fl_dq_oe_r <= 1'b0;
      end else begin
         fl_oe_n_r  <= ~(state_nxt == fws_pkg::FWS_READ);
         fl_we_n_r  <= ~(state_nxt == fws_pkg::FWS_RST);
         // Data held one cycle past the strobe's rise, where the flash latches it
         fl_dq_oe_r <= (state_nxt == fws_pkg::FWS_RST) || (state_r == fws_pkg::FWS_RST);
      end
   end
   // Sample at the end of each read; previous value kept for pairing
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         prev_r      <= 8'h00;
         last_r      <= 8'h00;
         have_prev_r <= 1'b0;
         tmo_seen_r  <= 1'b0;
      end else if (start && state_r == fws_pkg::FWS_IDLE) begin
         have_prev_r <= 1'b0;
         tmo_seen_r  <= 1'b0;
      end else if (state_r == fws_pkg::FWS_READ && cnt_end) begin
         prev_r <= last_r;
         last_r <= fl_dq_i;
      end else if (state_r == fws_pkg::FWS_EVAL) begin
         have_prev_r <= 1'b1;
         // Recheck once after the flag rises, since toggling may stop with it
         if (have_prev_r && toggling && timeout) tmo_seen_r <= 1'b1;
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         rb_r   <= 1'b0;
      end else begin
         rb_r <= ready_busy_pin_i;
         if (start && state_r == fws_pkg::FWS_IDLE) begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
            fail_r <= 1'b0;
         end else if (state_r == fws_pkg::FWS_EVAL && state_nxt == fws_pkg::FWS_IDLE) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
         end else if (state_r == fws_pkg::FWS_RST && cnt_end) begin
            busy_r <= 1'b0;
            fail_r <= 1'b1;
         end
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_SINGLE_DONE: assert property (@(posedge clock_i) disable iff (srst_i)
      (state_r == fws_pkg::FWS_EVAL && !have_prev_r) |=> state_r == fws_pkg::FWS_GAP)
      else $error("done decided on a single read");
   AST_DONE_NOTOG: assert property (@(posedge clock_i) disable iff (srst_i)
      $rose(done_r) |-> $past(!toggling))
      else $error("done while toggle bit differs");
   AST_FAIL_RESET: assert property (@(posedge clock_i) disable iff (srst_i)
      $rose(fail_r) |-> $past(!fl_we_n_r))
      else $error("fail without reset command");
   AST_RST_AFTER_TMO: assert property (@(posedge clock_i) disable iff (srst_i)
      (state_r == fws_pkg::FWS_EVAL && state_nxt == fws_pkg::FWS_RST) |-> tmo_seen_r)
      else $error("reset sent without timeout recheck");
   AST_RESTART: assert property (@(posedge clock_i) disable iff (srst_i)
      (start && state_r == fws_pkg::FWS_IDLE) |=> !have_prev_r)
      else $error("pairing not restarted");
   AST_READ_LEN: assert property (@(posedge clock_i) disable iff (srst_i)
      $fell(fl_oe_n_r) |-> !fl_oe_n_r [*3])
      else $error("read strobe too short");
   AST_READ_GAP: assert property (@(posedge clock_i) disable iff (srst_i)
      $rose(fl_oe_n_r) && busy_r |-> ##[1:2] (!fl_oe_n_r || !fl_we_n_r || !busy_r))
      else $error("read spacing wrong");
   AST_POL_DONE: assert property (@(posedge clock_i) disable iff (srst_i)
      $rose(done_r) |-> $past(pol_ok))
      else $error("done with polarity not settled");
   AST_NO_DRIVE_READ: assert property (@(posedge clock_i) disable iff (srst_i)
      !fl_oe_n_r |-> !fl_dq_oe_r)
      else $error("bus contention on read");
   AST_RECHECK: assert property (@(posedge clock_i) disable iff (srst_i)
      (state_r == fws_pkg::FWS_EVAL && have_prev_r && toggling && timeout && !tmo_seen_r)
      |=> state_r == fws_pkg::FWS_GAP)
      else $error("reset sent before the timeout recheck");
   AST_RST_DRIVE: assert property (@(posedge clock_i) disable iff (srst_i)
      !fl_we_n_r |-> fl_dq_oe_r && fl_oe_n_r)
      else $error("reset command strobe without data driven");
   AST_DQ_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
      $rose(fl_we_n_r) |-> fl_dq_oe_r)
      else $error("command data released with the strobe");
   AST_IDLE_QUIET: assert property (@(posedge clock_i) disable iff (srst_i)
      state_r == fws_pkg::FWS_IDLE |-> fl_oe_n_r && fl_we_n_r)
      else $error("flash strobed while idle");
   COV_DONE: cover property (@(posedge clock_i) $rose(done_r));
   COV_FAIL: cover property (@(posedge clock_i) $rose(fail_r));
   COV_ERASE: cover property (@(posedge clock_i) mode_erase && $rose(done_r));
   COV_PROG: cover property (@(posedge clock_i) !mode_erase && $rose(done_r));
   COV_RECHECK: cover property (@(posedge clock_i) state_r == fws_pkg::FWS_EVAL && tmo_seen_r);
endmodule : fws_poller

// [sim/fws_flash_model.sv]
// Behavioural flash device answering status polls from the controller
module fws_flash_model (
   input  wire logic       go_i,
   input  wire logic       erase_i,
   input  wire logic       stuck_i,
   input  wire logic [7:0] datum_i,
   input  wire logic [7:0] reads_i,
   input  wire logic       ce_n_i,
   input  wire logic       oe_n_i,
   input  wire logic       we_n_i,
   input  wire logic [7:0] dq_i,
   output logic      [7:0] dq_o,
   output logic            rb_o,
   output int              resets_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy = 1'b0;
   logic       tog = 1'b0;
   logic [7:0] left = 8'h00;
   logic [7:0] cur;
   initial resets_o = 0;
   // ----------------------------------------------------------------
   // Embedded operation
   // ----------------------------------------------------------------
   always @(posedge go_i) begin
      busy = 1'b1;
      left = reads_i;
   end
   // Toggle flips at the end of each read, so a read never sees a half-flipped bit
   always @(posedge oe_n_i) begin
      if (busy) begin
         tog = ~tog;
         if (!stuck_i && left == 8'h00) busy = 1'b0;
         else if (!stuck_i) left = left - 8'h01;
      end
   end
   always @(posedge we_n_i) begin
      if (dq_i === fws_pkg::RESET_CMD) begin
         busy = 1'b0;
         resets_o = resets_o + 1;
      end
   end
   // ----------------------------------------------------------------
   // Read data and ready pin
   // ----------------------------------------------------------------
   assign cur = busy ? {erase_i ? 1'b0 : ~datum_i[7], tog, stuck_i, 2'b00, erase_i & tog, 2'b00}
              : (erase_i ? 8'hFF : datum_i);
   // Released bus shows the inverse, so stale data never passes as valid
   assign dq_o = (!ce_n_i && !oe_n_i) ? cur : ~cur;
   assign rb_o = ~busy;
endmodule : fws_flash_model

// [sim/test_flash_write_status_reporting.sv]
// Self-checking bench for the flash status polling controller
module test_flash_write_status_reporting;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        psel, penable, pwrite, go, erase, stuck, pready, pslverr, err;
   logic        dq_oe, ce_n, oe_n, we_n, rb;
   logic [7:0]  paddr, datum, reads, dq_out, dq_dev, dq_bus;
   logic [31:0] pwdata, prdata, q;
   logic [21:0] fl_addr;
   logic [31:0] seed = 32'h0000_0020;
   int          num_errors = 0;
   int          comparisons = 0;
   int          resets;
   assign dq_bus = dq_oe ? dq_out : dq_dev;
   fws_poller i_dut (.clock_i(clock_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .fl_addr_o(fl_addr), .fl_dq_o(dq_out),
      .fl_dq_oe_o(dq_oe), .fl_dq_i(dq_bus), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n),
      .fl_we_n_o(we_n), .ready_busy_pin_i(rb));
   fws_flash_model i_flash (.go_i(go), .erase_i(erase), .stuck_i(stuck), .datum_i(datum),
      .reads_i(reads), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_bus),
      .dq_o(dq_dev), .rb_o(rb), .resets_o(resets));
   initial begin
      forever #12.5 clock_i = ~clock_i;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic test_done;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   // One APB transfer; waits for pready under a bound, then releases
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         check(32'h0, 32'h1, "bus answer timeout");
         test_done;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Start one operation, poll to the end and check the outcome
   task automatic run(input logic e, s, input logic [7:0] dat, nr, input logic [21:0] ad);
      int n;
      int r0;
      r0 = resets;
      datum <= dat;
      erase <= e;
      stuck <= s;
      reads <= nr;
      go <= 1'b1;
      apb(1'b1, fws_pkg::REG_ADDR, {10'h000, ad});
      go <= 1'b0;
      apb(1'b1, fws_pkg::REG_DATA, {24'h00_0000, dat});
      apb(1'b1, fws_pkg::REG_CTRL, {30'h0000_0000, e, 1'b1});
      apb(1'b0, fws_pkg::REG_STATUS, 32'h0);
      check({q[fws_pkg::ST_RB], q[fws_pkg::ST_BUSY]}, 32'h1, "busy with pin low");
      check(fl_addr, ad, "poll address");
      n = 0;
      do begin
         apb(1'b0, fws_pkg::REG_STATUS, 32'h0);
         n++;
      end while (q[fws_pkg::ST_DONE] !== 1'b1 && q[fws_pkg::ST_FAIL] !== 1'b1 && n < 300);
      if (n >= 300) begin
         check(32'h0, 32'h1, "poll never ended");
         test_done;
      end
      // Pin level reaches status one cycle after the fail flag, so read once more
      apb(1'b0, fws_pkg::REG_STATUS, 32'h0);
      check(q, s ? 32'hC : 32'hA, "final status");
      check(resets - r0, s ? 32'h1 : 32'h0, "reset commands");
      apb(1'b0, fws_pkg::REG_LAST, 32'h0);
      if (!s) check(q, {24'h00_0000, e ? 8'hFF : dat}, "last byte");
   endtask : run
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, go, erase, stuck} = 6'h00;
      {paddr, datum, reads, pwdata} = 56'h0;
      repeat (12) @(posedge clock_i);
      srst_i <= 1'b0;
      apb(1'b0, fws_pkg::REG_STATUS, 32'h0);
      check(q, 32'h8, "status after reset");
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped access error");
      run(1'b0, 1'b0, 8'h80, 8'h01, 22'h3F_FFFF);
      run(1'b0, 1'b0, 8'h7F, 8'h05, 22'h00_0000);
      run(1'b1, 1'b0, 8'h00, 8'h03, 22'h01_2000);
      run(1'b0, 1'b1, 8'h55, 8'h02, 22'h00_0100);
      run(1'b1, 1'b1, 8'h00, 8'h02, 22'h20_0000);
      for (int i = 0; i < 10; i++) begin
         seed = xs(seed);
         run(seed[0], 1'b0, seed[15:8], 8'h01 + {5'h00, seed[4:2]}, seed[31:10]);
      end
      test_done;
   end
endmodule : test_flash_write_status_reporting
